// *** bmfc_host.sv ***
// Host model of the boot serial link: byte sender and frame receiver.
`timescale 1ns/1ps
module bmfc_host #(
  parameter int BIT = 40
) (
  input  wire logic i_clk,
  input  wire logic i_txd,
  output logic      o_rxd
);
  logic [8:0] rq[$];  // Each entry is {start low and both stops high, byte}.
  logic [7:0] b;
  logic       ok;

  initial o_rxd = 1'b1;

  // host frame
  // A byte is start, eight data bits LSB first and two stop bits.
  task automatic send(input logic [7:0] d);
    logic [10:0] f;
    f = {2'b11, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge i_clk);
      o_rxd <= f[i];
      repeat (BIT - 1) @(posedge i_clk);
    end
  endtask

  // device frame
  // Samples mid-bit, so a wrong baud shows up as a corrupt byte.
  initial forever begin
    @(negedge i_txd);
    repeat (BIT / 2) @(posedge i_clk);
    ok = ~i_txd;
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge i_clk);
      b[i] = i_txd;
    end
    repeat (BIT) @(posedge i_clk);
    ok = ok & i_txd;
    repeat (BIT) @(posedge i_clk);
    rq.push_back({ok & i_txd, b});
  end
endmodule

// *** bmfc_pkg.sv ***
// Shared constants, state codes and carrier types of the boot sequencer.
package bmfc_pkg;
  localparam logic [15:0] BMFC_ROM_TOP      = 16'h01FF;
  localparam logic [15:0] BMFC_EXPANSION_RAM_LO      = 16'hF400;
  localparam logic [15:0] BMFC_FLASH_RUN_LO = 16'h0200;
  localparam logic [15:0] BMFC_SECT_A       = 16'hE000;
  localparam logic [15:0] BMFC_SECT_B       = 16'hC000;
  localparam logic [3:0]  BMFC_INFO_LAST    = 4'h9;
  // Marker bytes by offset: byte 0 is marker one, byte 3 is marker four.
  localparam logic [31:0] BMFC_ID_SEQ       = 32'h1333_0323;
  localparam logic [15:0] BMFC_VEC_T0       = 16'h000B;
  localparam logic [15:0] BMFC_VEC_T0_DST   = 16'hF400;
  localparam logic [15:0] BMFC_VEC_S0       = 16'h0023;
  localparam logic [15:0] BMFC_VEC_S0_DST   = 16'hF410;
  localparam logic [7:0]  BMFC_ACK          = 8'h55;
  localparam logic [7:0]  BMFC_ERR          = 8'hFF;
  localparam logic [7:0]  BMFC_MODE_LOAD    = 8'h00;
  localparam logic [7:0]  BMFC_MODE_RUN_X   = 8'h01;
  localparam logic [7:0]  BMFC_MODE_CHECK   = 8'h02;
  localparam logic [7:0]  BMFC_MODE_RUN_F   = 8'h03;
  localparam logic [2:0]  BMFC_NPAR_LOAD    = 3'h3;
  localparam logic [2:0]  BMFC_NPAR_CHECK   = 3'h5;
  localparam logic [2:0]  BMFC_NPAR_RUN     = 3'h2;
  // Start bit plus eight data bits are timed during the zero byte.
  localparam int          BMFC_SYNC_BITS    = 9;
  localparam int          BMFC_RECIP_SHIFT  = 9;
  localparam logic [6:0]  BMFC_RECIP_MUL    = 7'((2 ** BMFC_RECIP_SHIFT +
                                   BMFC_SYNC_BITS - 1) / BMFC_SYNC_BITS);
  localparam logic [3:0]  BMFC_TX_FRAME     = 4'hB;
  localparam logic [3:0]  BMFC_RX_STOP      = 4'h9;

  typedef enum logic [8:0] {
    ST_IDLE = 9'h001, ST_INFO = 9'h002, ST_SUM  = 9'h004,
    ST_FAIL = 9'h008, ST_SYNC = 9'h010, ST_SEND = 9'h020,
    ST_CMD  = 9'h040, ST_LOAD = 9'h080, ST_RUN  = 9'h100
  } bmfc_state_t;

  typedef struct packed {
    logic        valid;
    logic        expansion_ram;
    logic [15:0] addr;
  } bmfc_jump_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } bmfc_expansion_ram_wr_t;

  typedef struct packed {
    logic        rom;
    logic [15:0] addr;
  } bmfc_fetch_t;
endpackage

// *** bmfc_top.sv ***
// Boot-mode sequencer: flash software check, baud sync and command modes.
// Contract
// R1: Boot request pin high at reset or power-down release sets boot flag.
// R2: Boot mode maps the boot ROM over code 0000H to 01FFH.
// R3: Mode 0 stores host bytes in expansion RAM F400H-FFFFH, then commands.
// R4: Mode 1 jumps to a host address in expansion RAM F400H-FFFFH.
// R5: Mode 2 checksums a host-chosen flash area, then back to commands.
// R6: Mode 3 jumps into flash at a host address of 0200H or above.
// R7: Boot link frames are eight data bits, no parity, two stop bits.
// R8: The loader neither enables nor relies on any interrupt.
// R9: Boot mode redirects timer 0 vector 000BH to F400H.
// R10: Boot mode redirects serial 0 vector 0023H to F410H.
// R11: Loaded programs enable only timer 0 and serial 0 interrupts.
// R12: After entry check flash software; run it, else start serial setup.
// R13: Check sector A at E000H first, then sector B at C000H.
// R14: Info block: four markers, start, length (high first), two checksums.
// R15: Markers four to one must read 13H, 33H, 03H, 23H.
// R16: Missing markers mean the sector is not custom programmed.
// R17: Two checksums over start and length; both match jumps to start.
// R18: A failed sector A check repeats the whole check on sector B.
// R19: Both sectors failing starts serial setup on serial port 0.
// R20: Checksums add each byte then rotate left by one over 8 bits.
// R21: The host picks the working mode with header bytes.
// R22: First half of the region feeds checksum one, second half two.
// R23: Time the host zero byte, set the baud, reply with 55H.
// R24: After the acknowledge always enter the command phase.
`timescale 1ns/1ps
module bmfc_top (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_reset,
  input  wire logic                    i_boot_request_pin,
  input  wire logic                    i_hardware_power_down_n,
  input  wire logic                    i_rxd,
  input  wire logic [7:0]              i_flash_data,
  input  wire logic                    i_flash_valid,
  input  wire logic [15:0]             i_code_addr,
  output logic                         o_boot_mode_flag,
  output logic                         o_irq_hold,
  output logic                         o_txd,
  output logic                         o_flash_rd,
  output logic [16:0]                  o_flash_addr,
  output bmfc_pkg::bmfc_fetch_t        o_fetch,
  output bmfc_pkg::bmfc_jump_t         o_jump,
  output bmfc_pkg::bmfc_expansion_ram_wr_t      o_expansion_ram_wr
);
  import bmfc_pkg::*;

  // Every check below runs on the system clock and rests during reset.
  default clocking cb_sys @(posedge i_clk_sys);
  endclocking
  default disable iff (i_reset);

  logic [2:0]  async_in;
  logic [2:0]  sync1_ff;
  logic [2:0]  sync2_ff;
  logic        pin_s, hardware_power_down_n_s, rx_s;
  logic        rst_d_ff, hardware_power_down_n_d_ff, start_ev;
  bmfc_state_t st_ff;
  logic        sect_b_ff, rd_pend_ff, chk_mode_ff;
  logic [3:0]  idx_ff;
  logic [47:0] info_ff;
  logic [16:0] cur_ff;
  logic [15:0] pos_ff, wa_ff;
  logic [7:0]  cs1_ff, cs2_ff, mode_ff, load_n_ff;
  logic [39:0] hdr_ff, hdr_nx;
  logic [2:0]  hcnt_ff, npar;
  logic [15:0] snd_ff;
  logic [1:0]  snd_n_ff;
  logic        tx_go_ff;
  logic [7:0]  tx_byte_ff;
  logic [15:0] baud_ff, meas_ff, rx_tmr_ff, tx_tmr_ff;
  logic [22:0] prod;
  logic        baud_ok_ff, meas_on_ff, sync_done_ff, rx_on_ff;
  logic [3:0]  rx_bit_ff, tx_left_ff;
  logic [7:0]  rx_sh_ff, rx_data_ff;
  logic        rx_valid_ff;
  logic [10:0] tx_sh_ff;
  logic [15:0] sect_base;

  // Add then rotate left by one within the byte.
  function automatic logic [7:0] cs_step(input logic [7:0] cs,
                                          input logic [7:0] b);
    logic [7:0] s;
    s = cs + b;
    return {s[6:0], s[7]};
  endfunction

  // The boot request, power-down and receive pins pass two flops before any logic looks at them.
  assign async_in = {i_rxd, i_hardware_power_down_n, i_boot_request_pin};
  for (genvar gi = 0; gi < 3; gi++) begin : g_sync
    always_ff @(posedge i_clk_sys) begin
      sync1_ff[gi] <= async_in[gi];
      sync2_ff[gi] <= sync1_ff[gi];
    end
  end
  assign pin_s  = sync2_ff[0];
  assign hardware_power_down_n_s = sync2_ff[1];
  assign rx_s   = sync2_ff[2];

  // Entry event: first cycle after reset release or power-down release.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      rst_d_ff  <= 1'b1;
      hardware_power_down_n_d_ff <= 1'b1;
    end else begin
      rst_d_ff  <= 1'b0;
      hardware_power_down_n_d_ff <= hardware_power_down_n_s;
    end
  end
  assign start_ev = rst_d_ff | (hardware_power_down_n_s & ~hardware_power_down_n_d_ff);

  // R1: sample pin
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_boot_mode_flag <= 1'b0;
    end else if (start_ev) begin
      o_boot_mode_flag <= pin_s;
    end
  end

  // R8: hold interrupts
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_irq_hold <= 1'b0;
    end else begin
      o_irq_hold <= o_boot_mode_flag && st_ff != ST_RUN;
    end
  end

  // Code fetch mapping; vector redirection wins over the ROM window.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      o_fetch <= '0;
    end else if (o_boot_mode_flag && i_code_addr == BMFC_VEC_T0) begin
      // R9: timer vector
      o_fetch <= {1'b0, BMFC_VEC_T0_DST};
    end else if (o_boot_mode_flag && i_code_addr == BMFC_VEC_S0) begin
      // R10: serial vector
      o_fetch <= {1'b0, BMFC_VEC_S0_DST};
    end else begin
      // R2: ROM overlay
      o_fetch <= {o_boot_mode_flag && i_code_addr <= BMFC_ROM_TOP,
                  i_code_addr};
    end
  end

  assign sect_base = sect_b_ff ? BMFC_SECT_B : BMFC_SECT_A;
  assign hdr_nx    = {hdr_ff[31:0], rx_data_ff};
  assign npar = (mode_ff == BMFC_MODE_LOAD)  ? BMFC_NPAR_LOAD :
                (mode_ff == BMFC_MODE_CHECK) ? BMFC_NPAR_CHECK :
                BMFC_NPAR_RUN;

  // Main sequencer: flash check, sync, command phase. Reads are one at a
  // time, so the flash may answer after any latency.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      st_ff <= ST_IDLE;
      sect_b_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      chk_mode_ff <= 1'b0;
      idx_ff <= 4'h0;
      info_ff <= '0;
      cur_ff <= '0;
      pos_ff <= 16'h0000;
      wa_ff <= 16'h0000;
      cs1_ff <= 8'h00;
      cs2_ff <= 8'h00;
      mode_ff <= 8'h00;
      load_n_ff <= 8'h00;
      hdr_ff <= '0;
      hcnt_ff <= 3'h0;
      snd_ff <= 16'h0000;
      snd_n_ff <= 2'h0;
      tx_go_ff <= 1'b0;
      tx_byte_ff <= 8'h00;
      o_flash_rd <= 1'b0;
      o_flash_addr <= '0;
      o_jump <= '0;
      o_expansion_ram_wr <= '0;
    end else begin
      tx_go_ff <= 1'b0;
      o_flash_rd <= 1'b0;
      o_jump.valid <= 1'b0;
      o_expansion_ram_wr.we <= 1'b0;
      if (i_flash_valid) begin
        rd_pend_ff <= 1'b0;
      end
      if (start_ev) begin
        // R12: check first
        st_ff <= pin_s ? ST_INFO : ST_IDLE;
        sect_b_ff <= 1'b0;
        idx_ff <= 4'h0;
        rd_pend_ff <= 1'b0;
        chk_mode_ff <= 1'b0;
      end else begin
        case (st_ff)
          ST_INFO: begin
            if (!rd_pend_ff) begin
              // R13: sector base
              o_flash_rd <= 1'b1;
              o_flash_addr <= {1'b0, sect_base + {12'h000, idx_ff}};
              rd_pend_ff <= 1'b1;
            end else if (i_flash_valid) begin
              idx_ff <= idx_ff + 4'h1;
              // R14: info layout
              info_ff <= {info_ff[39:0], i_flash_data};
              // R15: marker bytes
              if (idx_ff < 4'h4 &&
                  i_flash_data != BMFC_ID_SEQ[idx_ff[1:0]*8 +: 8]) begin
                // R16: unprogrammed
                st_ff <= ST_FAIL;
              end else if (idx_ff == BMFC_INFO_LAST) begin
                cur_ff <= {1'b0, info_ff[39:24]};
                pos_ff <= 16'h0000;
                cs1_ff <= 8'h00;
                cs2_ff <= 8'h00;
                st_ff <= ST_SUM;
              end
            end
          end
          ST_SUM: begin
            if (pos_ff == info_ff[31:16] && !rd_pend_ff) begin
              if (chk_mode_ff) begin
                // R5: report sums
                snd_ff <= {cs1_ff, cs2_ff};
                snd_n_ff <= 2'h2;
                st_ff <= ST_SEND;
              end else if (cs1_ff == info_ff[15:8] &&
                           cs2_ff == info_ff[7:0]) begin
                // R17: both match
                o_jump <= {1'b1, 1'b0, info_ff[47:32]};
                st_ff <= ST_RUN;
              end else begin
                st_ff <= ST_FAIL;
              end
            end else if (!rd_pend_ff) begin
              o_flash_rd <= 1'b1;
              o_flash_addr <= cur_ff;
              rd_pend_ff <= 1'b1;
            end else if (i_flash_valid) begin
              cur_ff <= cur_ff + 17'h00001;
              pos_ff <= pos_ff + 16'h0001;
              // R22: halves
              if (pos_ff < {1'b0, info_ff[31:17]}) begin
                // R20: add rotate
                cs1_ff <= cs_step(cs1_ff, i_flash_data);
              end else begin
                cs2_ff <= cs_step(cs2_ff, i_flash_data);
              end
            end
          end
          ST_FAIL: begin
            if (!sect_b_ff) begin
              // R18: try sector B
              sect_b_ff <= 1'b1;
              idx_ff <= 4'h0;
              st_ff <= ST_INFO;
            end else begin
              // R19: serial setup
              st_ff <= ST_SYNC;
            end
          end
          ST_SYNC: begin
            if (sync_done_ff) begin
              // R23: acknowledge
              snd_ff <= {BMFC_ACK, 8'h00};
              snd_n_ff <= 2'h1;
              st_ff <= ST_SEND;
            end
          end
          ST_SEND: begin
            if (snd_n_ff == 2'h0) begin
              // R24: to commands
              hcnt_ff <= 3'h0;
              st_ff <= ST_CMD;
            end else if (!tx_go_ff && tx_left_ff == 4'h0) begin
              tx_go_ff <= 1'b1;
              tx_byte_ff <= snd_ff[15:8];
              snd_ff <= {snd_ff[7:0], 8'h00};
              snd_n_ff <= snd_n_ff - 2'h1;
            end
          end
          ST_CMD: begin
            if (rx_valid_ff && hcnt_ff == 3'h0) begin
              // R21: mode byte
              mode_ff <= rx_data_ff;
              hcnt_ff <= 3'h1;
              if (rx_data_ff > BMFC_MODE_RUN_F) begin
                snd_ff <= {BMFC_ERR, 8'h00};
                snd_n_ff <= 2'h1;
                st_ff <= ST_SEND;
              end
            end else if (rx_valid_ff && hcnt_ff != npar) begin
              hdr_ff <= hdr_nx;
              hcnt_ff <= hcnt_ff + 3'h1;
            end else if (rx_valid_ff) begin
              hdr_ff <= hdr_nx;
              snd_ff <= {BMFC_ERR, 8'h00};
              snd_n_ff <= 2'h1;
              st_ff <= ST_SEND;
              if (mode_ff == BMFC_MODE_LOAD &&
                  hdr_nx[23:8] >= BMFC_EXPANSION_RAM_LO) begin
                wa_ff <= hdr_nx[23:8];
                load_n_ff <= hdr_nx[7:0];
                st_ff <= ST_LOAD;
              end else if (mode_ff == BMFC_MODE_RUN_X &&
                           hdr_nx[15:0] >= BMFC_EXPANSION_RAM_LO) begin
                // R4: run in RAM
                o_jump <= {1'b1, 1'b1, hdr_nx[15:0]};
                st_ff <= ST_RUN;
              end else if (mode_ff == BMFC_MODE_CHECK) begin
                info_ff <= {hdr_nx[31:0], 16'h0000};
                cur_ff <= {hdr_nx[32], hdr_nx[31:16]};
                pos_ff <= 16'h0000;
                cs1_ff <= 8'h00;
                cs2_ff <= 8'h00;
                chk_mode_ff <= 1'b1;
                st_ff <= ST_SUM;
              end else if (mode_ff == BMFC_MODE_RUN_F &&
                           hdr_nx[15:0] >= BMFC_FLASH_RUN_LO) begin
                // R6: run in flash
                o_jump <= {1'b1, 1'b0, hdr_nx[15:0]};
                st_ff <= ST_RUN;
              end
            end
          end
          ST_LOAD: begin
            if (load_n_ff == 8'h00) begin
              snd_ff <= {BMFC_ACK, 8'h00};
              snd_n_ff <= 2'h1;
              st_ff <= ST_SEND;
            end else if (rx_valid_ff) begin
              // R3: store in RAM; bytes past FFFFH wrap and are dropped.
              o_expansion_ram_wr <= {wa_ff >= BMFC_EXPANSION_RAM_LO, wa_ff, rx_data_ff};
              wa_ff <= wa_ff + 16'h0001;
              load_n_ff <= load_n_ff - 8'h01;
            end
          end
          default: begin
            st_ff <= st_ff;
          end
        endcase
      end
    end
  end

  // Rounded scaled reciprocal of nine replaces a divider.
  assign prod = 23'(meas_ff * BMFC_RECIP_MUL);

  // Baud measurement and receiver; only the first stop bit is checked.
  always_ff @(posedge i_clk_sys) begin
    if (i_reset || start_ev) begin
      baud_ff <= 16'h0000;
      baud_ok_ff <= 1'b0;
      meas_ff <= 16'h0000;
      meas_on_ff <= 1'b0;
      sync_done_ff <= 1'b0;
      rx_on_ff <= 1'b0;
      rx_bit_ff <= 4'h0;
      rx_tmr_ff <= 16'h0000;
      rx_sh_ff <= 8'h00;
      rx_data_ff <= 8'h00;
      rx_valid_ff <= 1'b0;
    end else begin
      sync_done_ff <= 1'b0;
      rx_valid_ff <= 1'b0;
      if (st_ff == ST_SYNC && !baud_ok_ff) begin
        if (!meas_on_ff) begin
          meas_on_ff <= !rx_s;
          meas_ff <= 16'h0001;
        end else if (rx_s) begin
          // R23: set baud
          baud_ff <= {2'b00, prod[22:9]} + {15'h0000, prod[8]};
          baud_ok_ff <= 1'b1;
          sync_done_ff <= 1'b1;
          meas_on_ff <= 1'b0;
        end else if (meas_ff != 16'hFFFF) begin
          meas_ff <= meas_ff + 16'h0001;
        end
      end else if (baud_ok_ff && !rx_on_ff) begin
        if (!rx_s) begin
          rx_on_ff <= 1'b1;
          rx_bit_ff <= 4'h0;
          rx_tmr_ff <= {1'b0, baud_ff[15:1]};
        end
      end else if (rx_on_ff) begin
        if (rx_tmr_ff != 16'h0000) begin
          rx_tmr_ff <= rx_tmr_ff - 16'h0001;
        end else begin
          rx_tmr_ff <= baud_ff - 16'h0001;
          rx_bit_ff <= rx_bit_ff + 4'h1;
          rx_sh_ff <= {rx_s, rx_sh_ff[7:1]};
          if (rx_bit_ff == 4'h0 && rx_s) begin
            rx_on_ff <= 1'b0;
          end else if (rx_bit_ff == BMFC_RX_STOP) begin
            rx_on_ff <= 1'b0;
            rx_valid_ff <= rx_s;
            rx_data_ff <= rx_sh_ff;
          end
        end
      end
    end
  end

  // R7: 8N2 transmit
  always_ff @(posedge i_clk_sys) begin
    if (i_reset) begin
      tx_sh_ff <= 11'h7FF;
      tx_left_ff <= 4'h0;
      tx_tmr_ff <= 16'h0000;
    end else if (tx_go_ff) begin
      tx_sh_ff <= {2'b11, tx_byte_ff, 1'b0};
      tx_left_ff <= BMFC_TX_FRAME;
      tx_tmr_ff <= baud_ff - 16'h0001;
    end else if (tx_left_ff != 4'h0) begin
      if (tx_tmr_ff == 16'h0000) begin
        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
        tx_left_ff <= tx_left_ff - 4'h1;
        tx_tmr_ff <= baud_ff - 16'h0001;
      end else begin
        tx_tmr_ff <= tx_tmr_ff - 16'h0001;
      end
    end
  end
  assign o_txd = tx_sh_ff[0];

  AST_BOOT_FLAG: assert property ( // R1
    start_ev |=> o_boot_mode_flag == $past(pin_s))
    else $error("boot flag not taken from pin");
  AST_ROM_MAP: assert property ( // R2
    o_fetch.rom |-> $past(o_boot_mode_flag) && o_fetch.addr <= BMFC_ROM_TOP)
    else $error("rom window wrong");
  AST_EXPANSION_RAM_WR: assert property ( // R3
    o_expansion_ram_wr.we |-> o_expansion_ram_wr.addr >= BMFC_EXPANSION_RAM_LO && st_ff == ST_LOAD)
    else $error("ram write outside window");
  AST_RUN_X: assert property ( // R4
    o_jump.valid && o_jump.expansion_ram |-> o_jump.addr >= BMFC_EXPANSION_RAM_LO)
    else $error("ram jump below window");
  AST_RUN_F: assert property ( // R6
    o_jump.valid && $past(st_ff) == ST_CMD && !o_jump.expansion_ram
    |-> o_jump.addr >= BMFC_FLASH_RUN_LO)
    else $error("flash jump into rom");
  AST_IRQ_HOLD: assert property ( // R8
    o_boot_mode_flag && st_ff == ST_SYNC |=> o_irq_hold)
    else $error("interrupts not held");
  AST_VEC_T0: assert property ( // R9
    o_boot_mode_flag && i_code_addr == BMFC_VEC_T0 && !start_ev
    |=> o_fetch.addr == BMFC_VEC_T0_DST && !o_fetch.rom)
    else $error("timer vector not redirected");
  AST_VEC_S0: assert property ( // R10
    o_boot_mode_flag && i_code_addr == BMFC_VEC_S0 && !start_ev
    |=> o_fetch.addr == BMFC_VEC_S0_DST && !o_fetch.rom)
    else $error("serial vector not redirected");
  AST_SECT_A: assert property ( // R13
    o_flash_rd && st_ff == ST_INFO && !sect_b_ff
    |-> o_flash_addr[15:4] == BMFC_SECT_A[15:4])
    else $error("sector A read misplaced");
  AST_ACK_TX: assert property ( // R23
    sync_done_ff && st_ff == ST_SYNC
    |=> ##[1:3] tx_go_ff && tx_byte_ff == BMFC_ACK)
    else $error("no acknowledge after sync");
  AST_STOP: assert property ( // R7
    tx_go_ff |=> tx_sh_ff[10:9] == 2'b11 && !o_txd &&
    tx_left_ff == BMFC_TX_FRAME)
    else $error("tx frame not 8N2");
endmodule

// *** bmfc_top_tb_top.sv ***
// Self-checking bench: flash software check, sync and host commands.
`timescale 1ns/1ps
module bmfc_top_tb_top;
  import bmfc_pkg::*;
  logic          clk, rst, pin, pdn, rxd, fv, txd, flag, hold, frd;
  logic [7:0]    fdata;
  logic [15:0]   caddr;
  logic [16:0]   faddr, fr1;
  bmfc_fetch_t   fetch;
  bmfc_jump_t    jump, jl;
  bmfc_expansion_ram_wr_t xw;
  bmfc_expansion_ram_wr_t wq[$];
  logic [7:0]    fl [0:65535];
  logic [15:0]   cs;
  int            failures, checks, cyc, nrd;

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  bmfc_top i_bmfc_top (
    .i_clk_sys(clk), .i_reset(rst), .i_boot_request_pin(pin),
    .i_hardware_power_down_n(pdn), .i_rxd(rxd), .i_flash_data(fdata),
    .i_flash_valid(fv), .i_code_addr(caddr), .o_boot_mode_flag(flag),
    .o_irq_hold(hold), .o_txd(txd), .o_flash_rd(frd), .o_flash_addr(faddr),
    .o_fetch(fetch), .o_jump(jump), .o_expansion_ram_wr(xw)
  );

  bmfc_host #(.BIT(40)) i_bmfc_host (.i_clk(clk), .i_txd(txd), .o_rxd(rxd));

  // Flash answers one cycle late; jumps and writes are latched here so
  // that a pulse during a host send is not lost. Also the hang guard.
  always @(posedge clk) begin
    fv    <= frd;
    fdata <= fl[faddr[15:0]];
    if (frd && nrd == 0) fr1 <= faddr;
    if (frd) nrd <= nrd + 1;
    if (jump.valid) jl <= jump;
    if (xw.we) wq.push_back(xw);
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s expected %0h seen %0h", n, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Holds reset six cycles with the request pin steady, then settles.
  task automatic boot(input logic p);
    rst <= 1'b1;
    pin <= p;
    jl  <= '0;
    nrd = 0;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // Sends n bytes of v, most significant first.
  task automatic tx(input int n, input logic [47:0] v);
    for (int i = 0; i < n; i++) i_bmfc_host.send(v[8*(n-1-i) +: 8]);
  endtask

  task automatic reply(input logic [7:0] e);
    for (int i = 0; i < 3000 && i_bmfc_host.rq.size() == 0; i++)
      @(posedge clk);
    if (i_bmfc_host.rq.size() == 0) chk("reply", {24'h1, e}, 32'h0);
    else chk("reply", {24'h1, e}, 32'(i_bmfc_host.rq.pop_front()));
  endtask

  task automatic take_jump(input logic [17:0] e);
    for (int i = 0; i < 3000 && jl.valid !== 1'b1; i++) @(posedge clk);
    chk("jump", 32'(e), 32'(jl));
  endtask

  // Reference checksums: add, rotate left, first floor(n/2) bytes to one.
  function automatic logic [15:0] sums(input logic [15:0] a, input int n);
    logic [7:0] c1, c2, t;
    c1 = 8'h00;
    c2 = 8'h00;
    for (int i = 0; i < n; i++) begin
      t = ((i < n / 2) ? c1 : c2) + fl[a + 16'(i)];
      if (i < n / 2) c1 = {t[6:0], t[7]};
      else c2 = {t[6:0], t[7]};
    end
    return {c1, c2};
  endfunction

  // Builds an info block at s; x spoils the first stored checksum.
  task automatic info(input logic [15:0] s, input logic [15:0] st,
                      input logic [7:0] n, input logic [7:0] x);
    for (int i = 0; i < 4; i++)
      fl[s + 16'(i)] = 8'(32'h1333_0323 >> (8 * i));
    {fl[s + 4], fl[s + 5], fl[s + 6], fl[s + 7]} = {st, 8'h00, n};
    for (int i = 0; i < n; i++) fl[st + 16'(i)] = 8'h3C + 8'(i * 7);
    cs = sums(st, n);
    {fl[s + 8], fl[s + 9]} = cs ^ {x, 8'h00};
  endtask

  // Main sequence: flash check, then serial commands, then mode 3.
  initial begin
    rst = 1'b1;
    pin = 1'b0;
    pdn = 1'b1;
    fv = 1'b0;
    fdata = 8'h00;
    caddr = 16'h0000;
    failures = 0;
    checks = 0;
    cyc = 0;
    fl = '{default: 8'hFF};
    info(16'hE000, 16'hE00A, 8'd2, 8'h01);
    info(16'hC000, 16'hC00A, 8'd5, 8'h00);
    boot(1'b0);
    repeat (60) @(posedge clk);
    chk("flag", 0, flag);
    chk("jump", 0, 32'(jl));
    boot(1'b1);
    chk("flag", 1, flag);
    chk("hold", 1, hold);
    take_jump({1'b1, 1'b0, 16'hC00A});
    chk("hold", 0, hold);
    chk("first read", 32'h0E000, 32'(fr1));
    for (int i = 0; i < 4; i++) begin
      caddr <= 16'({16'h000B, 16'h0023, 16'h01FF, 16'h0200} >> (48 - 16 * i));
      repeat (2) @(posedge clk);
      chk("fetch", 32'({1'b0, 16'hF400, 1'b0, 16'hF410, 1'b1, 16'h01FF,
          1'b0, 16'h0200} >> (51 - 17 * i) & 17'h1FFFF),
          32'(fetch));
    end
    fl[16'hE000] = 8'h00;
    fl[16'hC003] = 8'h00;
    boot(1'b1);
    repeat (40) @(posedge clk);
    chk("jump", 0, 32'(jl));
    tx(1, 48'h00);
    reply(8'h55);
    tx(3, 48'h03_01FF);
    reply(BMFC_ERR);
    tx(3, 48'h01_F3FF);
    reply(BMFC_ERR);
    tx(6, 48'h00_F400_02_A5_5A);
    reply(8'h55);
    chk("writes", 2, wq.size());
    chk("wr0", 32'({1'b1, 16'hF400, 8'hA5}), 32'(wq[0]));
    chk("wr1", 32'({1'b1, 16'hF401, 8'h5A}), 32'(wq[1]));
    tx(6, 48'h02_00_C00A_0005);
    reply(cs[15:8]);
    reply(cs[7:0]);
    tx(3, 48'h01_F400);
    take_jump({1'b1, 1'b1, 16'hF400});
    boot(1'b1);
    repeat (40) @(posedge clk);
    tx(1, 48'h00);
    reply(8'h55);
    tx(3, 48'h03_0200);
    take_jump({1'b1, 1'b0, 16'h0200});
    // Power-down release re-samples the pin: first low, then high.
    for (int i = 0; i < 2; i++) begin
      pdn <= 1'b0;
      pin <= 1'(i);
      repeat (5) @(posedge clk);
      pdn <= 1'b1;
      repeat (8) @(posedge clk);
      chk("pd flag", i, flag);
    end
    chk("hold", 1, hold);
    end_of_test();
  end
endmodule
